// [mcp_pkg.sv]
`default_nettype none
package mcp_pkg;
    // bus widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int LOW_W  = 3;
    localparam int HIGH_W = 5;
    localparam int IRQ_W  = 8;

    // bit positions in the raw pin vector seen by the synchroniser
    localparam int PIN_W      = 16;
    localparam int PIN_DATA   = 0;
    localparam int PIN_A0     = 8;
    localparam int PIN_A1     = 9;
    localparam int PIN_A2     = 10;
    localparam int PIN_RD     = 11;
    localparam int PIN_WR     = 12;
    localparam int PIN_CS     = 13;
    localparam int PIN_RST    = 14;
    localparam int PIN_STYLE  = 15;

    // pin levels assumed while the synchroniser is in reset (bus idle)
    localparam logic [PIN_W-1:0] PIN_IDLE = 16'h7BFF;

    // values after reset
    localparam logic              OE_RST     = 1'b0;
    localparam logic              IRQ_N_RST  = 1'b1;
    localparam logic              MUX_RST    = 1'b0;
    localparam logic [ADDR_W-1:0] ADDR_RST   = 3'h0;
    localparam logic [DATA_W-1:0] DATA_RST   = 8'h00;

    // access sequencer states
    typedef enum logic [1:0] {
        MCP_IDLE  = 2'b00,
        MCP_READ  = 2'b01,
        MCP_WRITE = 2'b10
    } mcp_state_t;
endpackage
`default_nettype wire

// [mcp_pins_if.sv]
`default_nettype none
interface mcp_pins_if;
    logic [mcp_pkg::DATA_W-1:0] data;
    logic                       a0_mux;
    logic                       a1;
    logic                       addr2_or_latch_strobe;
    logic                       rd_ds_n;
    logic                       wr_dir;
    logic                       cs_n;
    logic                       hw_rst_n;
    logic                       style80;

    modport sync (output data, a0_mux, a1, addr2_or_latch_strobe, rd_ds_n, wr_dir, cs_n,
                  hw_rst_n, style80);
    modport port (input data, a0_mux, a1, addr2_or_latch_strobe, rd_ds_n, wr_dir, cs_n,
                  hw_rst_n, style80);
endinterface
`default_nettype wire

// [mcp_sync.sv]
`default_nettype none
module mcp_sync (
    // clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       srst_in,
    // raw pins
    input  wire logic [mcp_pkg::PIN_W-1:0]  pins_in,
    // synchronised pins
    mcp_pins_if.sync                        sync_out
);
    logic [mcp_pkg::PIN_W-1:0] meta_reg;
    logic [mcp_pkg::PIN_W-1:0] stable_reg;

    // strap pins keep flowing in reset, else the mode could never be
    // caught while reset holds the rest of the bus at idle
    localparam logic [mcp_pkg::PIN_W-1:0] STRAP_MASK =
        (16'h0001 << mcp_pkg::PIN_A0) | (16'h0001 << mcp_pkg::PIN_A1);

    // two flops per pin; the first is seen only by the second
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_reg   <= (pins_in & STRAP_MASK)
                        | (mcp_pkg::PIN_IDLE & ~STRAP_MASK);
            stable_reg <= (meta_reg & STRAP_MASK)
                        | (mcp_pkg::PIN_IDLE & ~STRAP_MASK);
        end else begin
            meta_reg   <= pins_in;
            stable_reg <= meta_reg;
        end
    end

    // unpack the stable vector
    assign sync_out.data     =
        stable_reg[mcp_pkg::PIN_DATA +: mcp_pkg::DATA_W];
    assign sync_out.a0_mux   = stable_reg[mcp_pkg::PIN_A0];
    assign sync_out.a1       = stable_reg[mcp_pkg::PIN_A1];
    assign sync_out.addr2_or_latch_strobe   = stable_reg[mcp_pkg::PIN_A2];
    assign sync_out.rd_ds_n  = stable_reg[mcp_pkg::PIN_RD];
    assign sync_out.wr_dir   = stable_reg[mcp_pkg::PIN_WR];
    assign sync_out.cs_n     = stable_reg[mcp_pkg::PIN_CS];
    assign sync_out.hw_rst_n = stable_reg[mcp_pkg::PIN_RST];
    assign sync_out.style80  = stable_reg[mcp_pkg::PIN_STYLE];
endmodule // mcp_sync
`default_nettype wire

// [mcp_host_port.sv]
// Behaviour
// - plain mode: address from three address pins
// - addr0 low, addr1 open selects multiplexed
// - multiplexed: low lines latched as address
// - 68xx: direction high reads, strobe moves data
// - 80xx: read strobe reads, write strobe writes
// - accesses only while chip select low
// - hardware reset pin low resets device except the interrupt pin
// - interrupt low while enabled condition pending
`default_nettype none
module mcp_host_port (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        srst_in,
    // host bus pins
    input  wire logic                        addr0_or_mux_select_in,
    input  wire logic                        addr_bit_one_in,
    input  wire logic                        addr2_or_latch_strobe_in,
    input  wire logic                        read_or_data_strobe_n_in,
    input  wire logic                        write_or_direction_in,
    input  wire logic                        chip_select_n_in,
    input  wire logic                        hardware_reset_n_in,
    input  wire logic                        bus_style_80xx_in,
    input  wire logic [mcp_pkg::LOW_W-1:0]   shared_addr_data_low_in,
    input  wire logic [mcp_pkg::HIGH_W-1:0]  data_upper_bits_in,
    output logic      [mcp_pkg::LOW_W-1:0]   shared_addr_data_low_out,
    output logic      [mcp_pkg::HIGH_W-1:0]  data_upper_bits_out,
    output logic                             data_oe_out,
    output logic                             interrupt_request_n_out,
    // core side
    output logic      [mcp_pkg::ADDR_W-1:0]  reg_addr_out,
    output logic      [mcp_pkg::DATA_W-1:0]  reg_wdata_out,
    output logic                             reg_wr_out,
    output logic                             reg_rd_out,
    input  wire logic [mcp_pkg::DATA_W-1:0]  reg_rdata_in,
    input  wire logic [mcp_pkg::IRQ_W-1:0]   irq_pending_in,
    input  wire logic [mcp_pkg::IRQ_W-1:0]   irq_enable_in,
    output logic                             core_reset_out,
    output logic                             mux_mode_out
);
    mcp_pins_if pins ();

    mcp_pkg::mcp_state_t         state_reg;
    mcp_pkg::mcp_state_t         state_next;
    logic [mcp_pkg::DATA_W-1:0]  dout_reg;
    logic                        oe_reg;
    logic                        irq_n_reg;
    logic [mcp_pkg::ADDR_W-1:0]  addr_reg;
    logic [mcp_pkg::ADDR_W-1:0]  addr_latch_reg;
    logic [mcp_pkg::DATA_W-1:0]  wdata_reg;
    logic                        wr_reg;
    logic                        rd_reg;
    logic                        core_rst_reg;
    logic                        mux_reg;
    logic                        hw_rst;
    logic                        any_rst;
    logic                        sel;
    logic                        rd_act;
    logic                        wr_act;
    logic [mcp_pkg::ADDR_W-1:0]  cur_addr;

    // every pin passes the two-flop synchroniser
    mcp_sync u_sync (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .pins_in  ({bus_style_80xx_in, hardware_reset_n_in,
                    chip_select_n_in, write_or_direction_in,
                    read_or_data_strobe_n_in, addr2_or_latch_strobe_in,
                    addr_bit_one_in, addr0_or_mux_select_in,
                    data_upper_bits_in, shared_addr_data_low_in}),
        .sync_out (pins.sync)
    );

    // decode of strobes in both bus styles
    assign hw_rst  = ~pins.hw_rst_n;
    assign any_rst = srst_in | hw_rst;
    assign sel     = ~pins.cs_n;
    always_comb begin
        if (pins.style80) begin
            rd_act = sel & ~pins.rd_ds_n;
            wr_act = sel & ~pins.wr_dir & pins.rd_ds_n;
        end else begin
            rd_act = sel & ~pins.rd_ds_n & pins.wr_dir;
            wr_act = sel & ~pins.rd_ds_n & ~pins.wr_dir;
        end
    end

    // address source depends on bus mode
    assign cur_addr = mux_reg ? addr_latch_reg
                    : {pins.addr2_or_latch_strobe, pins.a1, pins.a0_mux};

    // mode strap is caught while any reset is held
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            mux_reg <= ~pins.a0_mux & pins.a1;
        end
    end

    // transparent address latch while the latch strobe is high
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            addr_latch_reg <= mcp_pkg::ADDR_RST;
        end else if (mux_reg && pins.addr2_or_latch_strobe) begin
            addr_latch_reg <= pins.data[mcp_pkg::LOW_W-1:0];
        end
    end

    // access sequencer: one core read at entry, one core write at exit
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mcp_pkg::MCP_IDLE: begin
                if (rd_act) begin
                    state_next = mcp_pkg::MCP_READ;
                end else if (wr_act) begin
                    state_next = mcp_pkg::MCP_WRITE;
                end
            end
            mcp_pkg::MCP_READ: begin
                if (!rd_act) begin
                    state_next = mcp_pkg::MCP_IDLE;
                end
            end
            mcp_pkg::MCP_WRITE: begin
                if (!wr_act) begin
                    state_next = mcp_pkg::MCP_IDLE;
                end
            end
            default: begin
                state_next = mcp_pkg::MCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            state_reg <= mcp_pkg::MCP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // address captured once per access so it cannot move mid-cycle
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            addr_reg <= mcp_pkg::ADDR_RST;
        end else if (state_reg == mcp_pkg::MCP_IDLE
                     && (rd_act || wr_act)) begin
            addr_reg <= cur_addr;
        end
    end

    // core strobes; write fires when the host strobe ends
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
        end else begin
            rd_reg <= state_reg == mcp_pkg::MCP_IDLE && rd_act;
            wr_reg <= state_reg == mcp_pkg::MCP_WRITE && !wr_act;
        end
    end

    // write data follows the bus while the write strobe is held
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            wdata_reg <= mcp_pkg::DATA_RST;
        end else if (wr_act && state_reg != mcp_pkg::MCP_READ) begin
            wdata_reg <= pins.data;
        end
    end

    // read data and drive enable; off the bus unless reading
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            oe_reg   <= mcp_pkg::OE_RST;
            dout_reg <= mcp_pkg::DATA_RST;
        end else begin
            oe_reg   <= state_next == mcp_pkg::MCP_READ;
            dout_reg <= reg_rdata_in;
        end
    end

    // interrupt pin from enabled pending sources
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_n_reg <= mcp_pkg::IRQ_N_RST;
        end else begin
            irq_n_reg <= ~|(irq_pending_in & irq_enable_in);
        end
    end

    // core reset follows the synced reset pin
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_rst_reg <= 1'b1;
        end else begin
            core_rst_reg <= hw_rst;
        end
    end

    assign shared_addr_data_low_out = dout_reg[mcp_pkg::LOW_W-1:0];
    assign data_upper_bits_out      =
        dout_reg[mcp_pkg::DATA_W-1:mcp_pkg::LOW_W];
    assign data_oe_out              = oe_reg;
    assign interrupt_request_n_out  = irq_n_reg;
    assign reg_addr_out             = addr_reg;
    assign reg_wdata_out            = wdata_reg;
    assign reg_wr_out               = wr_reg;
    assign reg_rd_out               = rd_reg;
    assign core_reset_out           = core_rst_reg;
    assign mux_mode_out             = mux_reg;

    property p_plain_addr;
        @(posedge clk_in) disable iff (srst_in)
        (!any_rst && !mux_reg && state_reg == mcp_pkg::MCP_IDLE && rd_act)
        |=> addr_reg == $past({pins.addr2_or_latch_strobe, pins.a1, pins.a0_mux});
    endproperty
    a_plain_addr: assert property (p_plain_addr)
        else $error("plain mode address not taken from pins");

    property p_strap;
        @(posedge clk_in) disable iff (srst_in)
        hw_rst |=> mux_reg == $past(~pins.a0_mux & pins.a1);
    endproperty
    a_strap: assert property (p_strap)
        else $error("mux strap not caught in reset");

    property p_latch;
        @(posedge clk_in) disable iff (srst_in)
        (!any_rst && mux_reg && pins.addr2_or_latch_strobe)
        |=> addr_latch_reg == $past(pins.data[mcp_pkg::LOW_W-1:0]);
    endproperty
    a_latch: assert property (p_latch)
        else $error("multiplexed address not latched");

    property p_dir_read;
        @(posedge clk_in) disable iff (srst_in)
        (!any_rst && !pins.style80 && sel && !pins.rd_ds_n && pins.wr_dir
         && state_reg == mcp_pkg::MCP_IDLE) |=> rd_reg && oe_reg;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("68xx read not started");

    property p_wr_end;
        @(posedge clk_in) disable iff (srst_in)
        wr_reg |-> $past(state_reg == mcp_pkg::MCP_WRITE) && !$past(wr_act)
                   && reg_wdata_out == $past(wdata_reg);
    endproperty
    a_wr_end: assert property (p_wr_end)
        else $error("core write without finished host write");

    property p_deselect;
        @(posedge clk_in) disable iff (srst_in)
        !sel |=> !oe_reg && !rd_reg;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("activity while not selected");

    property p_hw_reset;
        @(posedge clk_in) disable iff (srst_in)
        hw_rst |=> core_rst_reg && state_reg == mcp_pkg::MCP_IDLE && !oe_reg;
    endproperty
    a_hw_reset: assert property (p_hw_reset)
        else $error("hardware reset not applied");

    property p_irq;
        @(posedge clk_in) disable iff (srst_in)
        1'b1 |=> irq_n_reg == !(|$past(irq_pending_in & irq_enable_in));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt pin wrong");

    property p_oe_read;
        @(posedge clk_in) disable iff (srst_in)
        oe_reg |-> $past(rd_act) && state_reg == mcp_pkg::MCP_READ;
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("data driven outside a read");
endmodule // mcp_host_port
`default_nettype wire

// [mcp_host_model.sv]
`default_nettype none
module mcp_host_model (
    // clock
    input  wire logic       clk_in,
    // pins toward the device
    output logic            a0_out,
    output logic            a1_out,
    output logic            a2_out,
    output logic            rd_n_out,
    output logic            wr_out,
    output logic            cs_n_out,
    output logic            s80_out,
    output logic [7:0]      bus_out,
    // device drive of the data lines
    input  wire logic [7:0] dev_data_in,
    input  wire logic       dev_oe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       drv;
    logic [7:0] hd;
    logic       mux;

    // released lines float up to the pull-ups, never the last value
    assign bus_out = dev_oe_in ? dev_data_in : (drv ? hd : 8'hFF);

    // bus idle at time zero
    initial begin
        {drv, hd, mux} = 10'h000;
        {a2_out, a1_out, a0_out} = 3'h3; // addr0 high: plain bus strap
        {rd_n_out, wr_out, cs_n_out, s80_out} = 4'hF;
    end

    // strap: addr0 low with addr1 open selects multiplexing
    task automatic strap(input logic m);
        mux = m;
        a0_out <= !m;
        a1_out <= 1'b1;
        a2_out <= 1'b0; // latch strobe idle
    endtask

    // one access; fixed strobe length, no handshake on this bus
    task automatic access(input logic s80, input logic sel, input logic rd,
                          input logic [2:0] ad, input logic [7:0] wd,
                          output logic [7:0] rdat);
        @(posedge clk_in);
        s80_out <= s80;
        repeat (3) @(posedge clk_in);
        if (mux) begin
            drv <= 1'b1;
            hd <= {5'h00, ad};
            a2_out <= 1'b1;
            repeat (2) @(posedge clk_in);
            a2_out <= 1'b0;
            @(posedge clk_in);
        end else begin
            {a2_out, a1_out, a0_out} <= ad;
        end
        drv <= !rd;
        hd <= wd;
        cs_n_out <= !sel;
        rd_n_out <= s80 ? !rd : 1'b0;
        wr_out <= rd;
        repeat (7) @(posedge clk_in);
        @(negedge clk_in);
        rdat = bus_out;
        @(posedge clk_in);
        {cs_n_out, rd_n_out, wr_out} <= 3'h7;
        drv <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask
endmodule // mcp_host_model
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 1'b0;
    logic       srst_in = 1'b1;
    logic       hw_rst_n = 1'b1;
    logic [7:0] rdata = 8'h00;
    logic [7:0] pend = 8'h00;
    logic [7:0] en = 8'h00;
    logic       a0, a1, a2, rd_n, wr, cs_n, s80, oe, irq_n, core_rst, mux;
    logic       reg_wr, reg_rd;
    logic [7:0] bus, dev_data, wdata, w_data, rdat;
    logic [2:0] addr, w_addr;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         wr_cnt = 0;
    int         rd_cnt = 0;

    mcp_host_port i_dut (
        .clk_in(clk_in), .srst_in(srst_in),
        .addr0_or_mux_select_in(a0), .addr_bit_one_in(a1),
        .addr2_or_latch_strobe_in(a2), .read_or_data_strobe_n_in(rd_n),
        .write_or_direction_in(wr), .chip_select_n_in(cs_n),
        .hardware_reset_n_in(hw_rst_n), .bus_style_80xx_in(s80),
        .shared_addr_data_low_in(bus[2:0]), .data_upper_bits_in(bus[7:3]),
        .shared_addr_data_low_out(dev_data[2:0]),
        .data_upper_bits_out(dev_data[7:3]), .data_oe_out(oe),
        .interrupt_request_n_out(irq_n), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_rdata_in(rdata), .irq_pending_in(pend), .irq_enable_in(en),
        .core_reset_out(core_rst), .mux_mode_out(mux));

    mcp_host_model i_host (
        .clk_in(clk_in), .a0_out(a0), .a1_out(a1), .a2_out(a2),
        .rd_n_out(rd_n), .wr_out(wr), .cs_n_out(cs_n), .s80_out(s80),
        .bus_out(bus), .dev_data_in(dev_data), .dev_oe_in(oe));

    // clock; start-up reset is released in the main sequence
    initial begin
        forever #10 clk_in = ~clk_in;
    end

    // core stand-in: register contents depend on the address
    function automatic logic [7:0] pat(input logic [2:0] a);
        return 8'h5A ^ {a, 2'h0, a};
    endfunction

    // core stand-in and write/read pulse monitor
    always @(posedge clk_in) begin
        rdata <= pat(addr);
        if (reg_wr === 1'b1) begin
            wr_cnt++;
            {w_addr, w_data} = {addr, wdata};
        end
        if (reg_rd === 1'b1) rd_cnt++;
    end

    // hang guard, well above the roughly 1300 cycles the run needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // write then read back each address from lo to hi in one control style
    task automatic t_rw(input logic st, input logic [2:0] lo, hi);
        int w0;
        int r0;
        for (int i = lo; i <= hi; i++) begin
            w0 = wr_cnt;
            r0 = rd_cnt;
            i_host.access(st, 1'b1, 1'b0, 3'(i), {~3'(i), 2'h2, 3'(i)}, rdat);
            chk(8'(wr_cnt - w0), 8'h01);
            chk({5'h00, w_addr}, 8'(i));
            chk(w_data, {~3'(i), 2'h2, 3'(i)});
            i_host.access(st, 1'b1, 1'b1, 3'(i), 8'h00, rdat);
            chk(rdat, pat(3'(i)));
            chk(8'(rd_cnt - r0), 8'h01);
            chk({7'h00, oe}, 8'h00);
        end
    endtask

    // strobes without chip select reach nothing
    task automatic t_refuse();
        int w0;
        w0 = wr_cnt + rd_cnt;
        for (int s = 0; s < 2; s++) begin
            i_host.access(1'(s), 1'b0, 1'b0, 3'h3, 8'h3C, rdat);
            i_host.access(1'(s), 1'b0, 1'b1, 3'h3, 8'h00, rdat);
            chk(rdat, 8'hFF);
        end
        chk(8'(wr_cnt + rd_cnt - w0), 8'h00);
    endtask

    // each source alone, enabled then masked
    task automatic t_irq();
        for (int i = 0; i < 8; i++) begin
            pend <= 8'h01 << i;
            en <= 8'h01 << i;
            repeat (3) @(posedge clk_in);
            chk({7'h00, irq_n}, 8'h00);
            en <= ~(8'h01 << i);
            repeat (3) @(posedge clk_in);
            chk({7'h00, irq_n}, 8'h01);
        end
    endtask

    // pin reset reaches the core and lets go again
    task automatic t_hwrst();
        hw_rst_n <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk({7'h00, core_rst}, 8'h01);
        hw_rst_n <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk({7'h00, core_rst}, 8'h00);
    endtask

    // restart with the multiplex strap, then run both styles
    task automatic t_mux();
        srst_in <= 1'b1;
        i_host.strap(1'b1);
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk({7'h00, mux}, 8'h01);
        t_rw(1'b1, 3'h0, 3'h7);
        t_rw(1'b0, 3'h2, 3'h5);
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk({7'h00, mux}, 8'h00);
        t_rw(1'b1, 3'h0, 3'h7);
        t_rw(1'b0, 3'h0, 3'h7);
        t_refuse();
        t_irq();
        t_hwrst();
        t_rw(1'b1, 3'h6, 3'h7);
        t_mux();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
